// [hw/rdac_top.sv]
// top of the reference ladder control block with an AXI4-Lite slave
// Summary of operation
// (RULE_01) ladder is active only while converter_enable is set.
// (RULE_02) 5-bit level_code selects one of 32 ladder taps.
// (RULE_03) tap output is negative source plus difference times code over 32.
// (RULE_04) low-power select set drops negative source, clear drops positive source.
// (RULE_05) disabled, low-power set, code all ones: output equals positive source.
// (RULE_06) disabled, low-power clear, code all zeros: output equals negative source.
// (RULE_07) pin_output_enable set routes the converter level onto the output pin.
// (RULE_08) pin_output_enable set overrides pin driver and disables its input detector.
// (RULE_09) digital read of the pin returns zero while it carries the level.
// (RULE_10) unimplemented bits of both registers ignore writes and read zero.
// (RULE_11) positive select: 00 supply, 01 external ref, 10 fixed buffer, 11 reserved.
// (RULE_12) negative select one picks external negative reference, zero picks ground.
// (RULE_13) reset disables converter, frees the pin and clears the level code.
// (RULE_14) wake from sleep leaves the main control register unchanged.
// (RULE_15) register writes reach the analog controls on the following clock edge.
`timescale 1ns/1ps
`default_nettype none
module rdac_top (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [3:0]         s_axi_awaddr,
  input  wire logic [2:0]         s_axi_awprot,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [3:0]         s_axi_araddr,
  input  wire logic [2:0]         s_axi_arprot,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               pin_digital_in,
  output logic                    pin_digital_read,
  output rdac_pkg::rdac_analog_t  analog,
  output rdac_pkg::rdac_pin_t     pin
);
  import rdac_pkg::*;

  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [7:0]  w_byte;
  logic        w_lane0;
  logic        wr_fire;
  logic        wr_main;
  logic        wr_level;
  logic        wr_hit;
  logic [7:0]  control_main;
  logic [7:0]  level_select;
  logic [7:0]  rd_byte;
  logic        rd_hit;

  // address map check used by the read path only; writes decode wr_hit instead
  function automatic logic addr_mapped(input logic [3:0] a);
    addr_mapped = (a == ADDR_CONTROL_MAIN) || (a == ADDR_LEVEL_SELECT) || (a == ADDR_PIN_STATUS);
  endfunction : addr_mapped

  // each channel accepted once; no new ones while a response waits
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
  // byte lane 0 only carries register data; other lanes ignored
  assign wr_hit   = (aw_addr == ADDR_CONTROL_MAIN) || (aw_addr == ADDR_LEVEL_SELECT);
  assign wr_main  = wr_fire && w_lane0 && (aw_addr == ADDR_CONTROL_MAIN);
  assign wr_level = wr_fire && w_lane0 && (aw_addr == ADDR_LEVEL_SELECT);

  // write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held  <= 1'b0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held  <= 1'b1;
      w_byte  <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held  <= 1'b0;
    end
  end

  // write response; status register is read-only, so slverr there too
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  rdac_regs u_regs (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .wr_main      (wr_main),
    .wr_level     (wr_level),
    .wr_byte      (w_byte),
    .control_main (control_main),
    .level_select (level_select)
  );

  rdac_ladder u_ladder (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .control_main (control_main),
    .level_select (level_select),
    .analog       (analog),
    .pin          (pin)
  );

  // pin read forced low while it carries the analog level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_digital_read <= 1'b0;
    end else begin
      pin_digital_read <= pin_digital_in && !control_main[BIT_PIN_OE]; // RULE_09
    end
  end

  // read data mux
  always_comb begin
    rd_hit  = addr_mapped(s_axi_araddr);
    rd_byte = 8'h00;
    case (s_axi_araddr)
      ADDR_CONTROL_MAIN: rd_byte = control_main; // RULE_10
      ADDR_LEVEL_SELECT: rd_byte = level_select; // RULE_10
      ADDR_PIN_STATUS:   rd_byte = {7'h00, pin_digital_read};
      default:           rd_byte = 8'h00;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  // read channel, one cycle after address accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks on the registered controls
  enable_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    analog.ladder_on == $past(control_main[BIT_ENABLE])) else $error("ladder enable mismatch"); // RULE_01
  // the first edge after release still shows the all-zero reset outputs
  tap_onehot_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> analog.tap_onehot == (32'h0000_0001 << $past(level_select[4:0])))
    else $error("tap select wrong"); // RULE_02
  source_power_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) && !$past(control_main[BIT_ENABLE]) |-> (analog.neg_source_connect != analog.pos_source_connect))
    else $error("low power source wrong"); // RULE_04
  clamp_pos_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!control_main[BIT_ENABLE] && control_main[BIT_LOW_POWER] && level_select[4:0] == LEVEL_ALL_ONES)
    |=> (analog.tap_onehot[31] && analog.pos_source_connect && !analog.neg_source_connect))
    else $error("positive clamp wrong"); // RULE_05
  clamp_neg_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!control_main[BIT_ENABLE] && !control_main[BIT_LOW_POWER] && level_select[4:0] == LEVEL_ALL_ZEROS)
    |=> (analog.tap_onehot[0] && analog.neg_source_connect && !analog.pos_source_connect))
    else $error("negative clamp wrong"); // RULE_06
  pin_override_a: assert property (@(posedge aclk) disable iff (!aresetn)
    control_main[BIT_PIN_OE] |=> (pin.pin_analog_route && pin.pin_driver_override && pin.pin_input_disable))
    else $error("pin override missing"); // RULE_07
  pin_read_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    control_main[BIT_PIN_OE] |=> !pin_digital_read) else $error("pin read not zero"); // RULE_09
  reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((control_main & ~MASK_CONTROL_MAIN) == 8'h00) && ((level_select & ~MASK_LEVEL_SELECT) == 8'h00))
    else $error("reserved bit set"); // RULE_10
  psel_unique_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(control_main[3:2]) == PSRC_FIXED |-> analog.psel_fixed && !analog.psel_supply)
    else $error("positive select wrong"); // RULE_11
  nsel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    analog.nsel_ext_ref == $past(control_main[BIT_NSS])) else $error("negative select wrong"); // RULE_12
  reset_clear_a: assert property (@(posedge aclk)
    !aresetn |=> (!analog.ladder_on && !pin.pin_analog_route && level_select == RESET_LEVEL))
    else $error("reset did not clear"); // RULE_13
  write_latency_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_main |=> ##1 (analog.ladder_on == $past(w_byte[BIT_ENABLE], 2)))
    else $error("write latency wrong"); // RULE_15

  cov_write_c: cover property (@(posedge aclk) wr_main);
  cov_read_c:  cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
  cov_clamp_c: cover property (@(posedge aclk) analog.tap_onehot[31] && !analog.ladder_on);
  cov_pin_c:   cover property (@(posedge aclk) pin.pin_analog_route);
endmodule : rdac_top
`default_nettype wire

// [hw/rdac_pkg.sv]
// package for the reference ladder control block: offsets, fields, types
package rdac_pkg;
  // register byte addresses on the register bus
  localparam logic [3:0] ADDR_CONTROL_MAIN  = 4'h0;
  localparam logic [3:0] ADDR_LEVEL_SELECT  = 4'h4;
  localparam logic [3:0] ADDR_PIN_STATUS    = 4'h8;
  // field positions in reference_control_main
  localparam int BIT_ENABLE    = 7;
  localparam int BIT_LOW_POWER = 6;
  localparam int BIT_PIN_OE    = 5;
  localparam int BIT_PSS_HI    = 3;
  localparam int BIT_PSS_LO    = 2;
  localparam int BIT_NSS       = 0;
  // writable masks, unimplemented bits read zero
  localparam logic [7:0] MASK_CONTROL_MAIN = 8'h00ED;
  localparam logic [7:0] MASK_LEVEL_SELECT = 8'h001F;
  localparam logic [7:0] RESET_CONTROL     = 8'h0000;
  localparam logic [7:0] RESET_LEVEL       = 8'h0000;
  localparam int         LEVEL_BITS        = 5;
  localparam logic [4:0] LEVEL_ALL_ONES    = 5'h1F;
  localparam logic [4:0] LEVEL_ALL_ZEROS   = 5'h00;
  localparam logic [1:0] RESP_OKAY         = 2'h0;
  localparam logic [1:0] RESP_SLVERR       = 2'h2;

  // positive source codes
  typedef enum logic [1:0] {
    PSRC_SUPPLY   = 2'h0,
    PSRC_EXT_REF  = 2'h1,
    PSRC_FIXED    = 2'h2,
    PSRC_RESERVED = 2'h3
  } rdac_psrc_t;

  // analog control bundle towards the ladder and switches
  typedef struct packed {
    logic       ladder_on;
    logic       pos_source_connect;
    logic       neg_source_connect;
    logic       psel_supply;
    logic       psel_ext_ref;
    logic       psel_fixed;
    logic       nsel_ext_ref;
    logic       nsel_ground;
    logic [31:0] tap_onehot;
  } rdac_analog_t;

  // pin override bundle for the reference output pin
  typedef struct packed {
    logic pin_analog_route;
    logic pin_driver_override;
    logic pin_input_disable;
  } rdac_pin_t;
endpackage : rdac_pkg

// [hw/rdac_regs.sv]
// register storage for the two control registers, writes masked
`timescale 1ns/1ps
`default_nettype none
module rdac_regs (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       wr_main,
  input  wire logic       wr_level,
  input  wire logic [7:0] wr_byte,
  output logic [7:0]      control_main,
  output logic [7:0]      level_select
);
  import rdac_pkg::*;

  // main control; no sleep input exists, so wake keeps contents  RULE_14
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_main <= RESET_CONTROL; // RULE_13
    end else if (wr_main) begin
      control_main <= wr_byte & MASK_CONTROL_MAIN; // RULE_10
    end
  end

  // level code register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_select <= RESET_LEVEL; // RULE_13
    end else if (wr_level) begin
      level_select <= wr_byte & MASK_LEVEL_SELECT; // RULE_10
    end
  end
endmodule : rdac_regs
`default_nettype wire

// [hw/rdac_ladder.sv]
// decode of control bits into ladder, switch and pin controls
`timescale 1ns/1ps
`default_nettype none
module rdac_ladder (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          control_main,
  input  wire logic [7:0]          level_select,
  output rdac_pkg::rdac_analog_t   analog,
  output rdac_pkg::rdac_pin_t      pin
);
  import rdac_pkg::*;

  // one-hot tap from the 5-bit code
  function automatic logic [31:0] tap_decode(input logic [4:0] code);
    tap_decode = 32'h0000_0001 << code;
  endfunction : tap_decode

  rdac_analog_t next_analog;
  rdac_pin_t    next_pin;
  logic [1:0]   pss;

  // combinational decode of the analog controls
  always_comb begin
    pss = control_main[BIT_PSS_HI:BIT_PSS_LO];
    next_analog = '0;
    next_analog.ladder_on = control_main[BIT_ENABLE]; // RULE_01
    // low-power: set drops negative end, clear drops positive end
    next_analog.pos_source_connect = control_main[BIT_ENABLE] | control_main[BIT_LOW_POWER]; // RULE_04
    next_analog.neg_source_connect = control_main[BIT_ENABLE] | ~control_main[BIT_LOW_POWER]; // RULE_04 RULE_05 RULE_06
    // reserved positive code connects nothing, safest choice
    next_analog.psel_supply  = (pss == PSRC_SUPPLY); // RULE_11
    next_analog.psel_ext_ref = (pss == PSRC_EXT_REF); // RULE_11
    next_analog.psel_fixed   = (pss == PSRC_FIXED); // RULE_11
    next_analog.nsel_ext_ref = control_main[BIT_NSS]; // RULE_12
    next_analog.nsel_ground  = ~control_main[BIT_NSS]; // RULE_12
    // tap k gives neg + (pos-neg)*k/32  RULE_02 RULE_03
    next_analog.tap_onehot   = tap_decode(level_select[LEVEL_BITS-1:0]);
    next_pin.pin_analog_route    = control_main[BIT_PIN_OE]; // RULE_07
    next_pin.pin_driver_override = control_main[BIT_PIN_OE]; // RULE_08
    next_pin.pin_input_disable   = control_main[BIT_PIN_OE]; // RULE_08
  end

  // outputs registered; follow register one edge later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog <= '0; // RULE_13
      pin    <= '0; // RULE_13
    end else begin
      analog <= next_analog; // RULE_15
      pin    <= next_pin; // RULE_15
    end
  end
endmodule : rdac_ladder
`default_nettype wire

// [verification/rdac_far_side.sv]
// model of the ladder tap and output pin beyond the block
`timescale 1ns/1ps
`default_nettype none
module rdac_far_side (
  input  wire logic                   aclk,
  input  wire rdac_pkg::rdac_analog_t analog,
  input  wire rdac_pkg::rdac_pin_t    pin,
  input  wire logic                   ext_level,
  output logic                        pin_digital_in,
  output logic [5:0]                  out_tap
);
  import rdac_pkg::*;
  logic toggle = 1'b0;
  // the level in 32nds of the source span, taken from the one-hot tap
  always_comb begin
    out_tap = 6'h00;
    for (int k = 0; k < 32; k++) begin
      if (analog.tap_onehot[k]) out_tap = 6'(k);
    end
  end
  // an analog pin gives no sound digital level, so show a changing one
  always_ff @(posedge aclk) toggle <= ~toggle;
  assign pin_digital_in = pin.pin_analog_route ? toggle : ext_level;
endmodule : rdac_far_side
`default_nettype wire

// [verification/rdac_top_test.sv]
// self-checking bench for the reference ladder control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("wrong value at %0t: %h not %h", $time, a, b); end end
module rdac_top_test;
  import rdac_pkg::*;
  typedef struct packed { logic [31:0] d; logic [1:0] r; } rdac_note_t;
  logic aclk = 1'b0, aresetn = 1'b0, ext_level = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h1;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, pin_in, pin_rd;
  logic [1:0] bresp, rresp;
  logic [5:0] out_tap;
  rdac_analog_t analog;
  rdac_pin_t pin;
  rdac_note_t wq[$], rq[$], nt;
  int errors = 0, n_compared = 0, cycles = 0;
  logic [7:0] m, l;
  rdac_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_digital_in(pin_in), .pin_digital_read(pin_rd), .analog(analog), .pin(pin));
  rdac_far_side far_u (.aclk(aclk), .analog(analog), .pin(pin), .ext_level(ext_level),
    .pin_digital_in(pin_in), .out_tap(out_tap));
  initial forever #12.5 aclk = ~aclk;
  // hang guard, well above the length of the sequence
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      complete_run();
    end
  end
  // monitor: every response is matched against the oldest note
  always @(posedge aclk) begin
    if (bvalid && bready && wq.size() > 0) begin
      nt = wq.pop_front();
      `CHK(bresp, nt.r)
    end
    if (rvalid && rready && rq.size() > 0) begin
      nt = rq.pop_front();
      `CHK(rdata, nt.d)
      `CHK(rresp, nt.r)
    end
  end
  // write both channels together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    wq.push_back('{32'h0000_0000, r});
    @(posedge aclk);
    awaddr <= a; awvalid <= 1; wdata <= {$urandom} & 32'hFFFF_FF00 | 32'(v); wvalid <= 1; bready <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin aw_ok = 1; awvalid <= 0; end
      if (wvalid && wready) begin w_ok = 1; wvalid <= 0; end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back('{d, r});
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 0;
  endtask : rd
  // expected switch and tap controls for a pair of register values
  function automatic rdac_analog_t exp_an(input logic [7:0] c, input logic [4:0] v);
    rdac_analog_t e;
    e = '0;
    e.ladder_on = c[BIT_ENABLE];
    e.pos_source_connect = c[BIT_ENABLE] | c[BIT_LOW_POWER];
    e.neg_source_connect = c[BIT_ENABLE] | !c[BIT_LOW_POWER];
    e.psel_supply = c[3:2] == 2'h0;
    e.psel_ext_ref = c[3:2] == 2'h1;
    e.psel_fixed = c[3:2] == 2'h2;
    e.nsel_ext_ref = c[BIT_NSS];
    e.nsel_ground = !c[BIT_NSS];
    e.tap_onehot = 32'h0000_0001 << v;
    return e;
  endfunction : exp_an
  task automatic reset_dut();
    aresetn <= 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    #1;
    `CHK(analog, exp_an(RESET_CONTROL, RESET_LEVEL[4:0]))
    `CHK(pin, rdac_pin_t'('0))
    rd(ADDR_CONTROL_MAIN, 32'h0000_0000, RESP_OKAY);
    rd(ADDR_LEVEL_SELECT, 32'h0000_0000, RESP_OKAY);
  endtask : reset_dut
  task automatic complete_run();
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  initial begin
    void'($urandom(79));
    reset_dut();
    // random settings, every positive code, both clamp cases first
    for (int i = 0; i < 12; i++) begin
      m = 8'($urandom);
      l = 8'($urandom);
      m[3:2] = 2'(i);
      if (i < 2) begin
        m[7:6] = {1'b0, !i[0]};
        l[4:0] = i[0] ? LEVEL_ALL_ZEROS : LEVEL_ALL_ONES;
      end
      wr(ADDR_CONTROL_MAIN, m, RESP_OKAY);
      wr(ADDR_LEVEL_SELECT, l, RESP_OKAY);
      @(posedge aclk);
      #1;
      `CHK(analog, exp_an(m & MASK_CONTROL_MAIN, l[4:0]))
      `CHK(out_tap, 6'(l[4:0]))
      `CHK(pin, rdac_pin_t'({3{m[BIT_PIN_OE]}}))
      rd(ADDR_CONTROL_MAIN, 32'(m & MASK_CONTROL_MAIN), RESP_OKAY);
      rd(ADDR_LEVEL_SELECT, 32'(l & MASK_LEVEL_SELECT), RESP_OKAY);
    end
    // pin status with the pin digital, then carrying the level
    ext_level <= 1;
    wr(ADDR_CONTROL_MAIN, 8'h0080, RESP_OKAY);
    rd(ADDR_PIN_STATUS, 32'h0000_0001, RESP_OKAY);
    wr(ADDR_CONTROL_MAIN, 8'h00A0, RESP_OKAY);
    repeat (3) @(posedge aclk);
    #1;
    `CHK(pin_rd, 1'b0)
    rd(ADDR_PIN_STATUS, 32'h0000_0000, RESP_OKAY);
    // refused places: read-only status and an unmapped word
    wr(ADDR_PIN_STATUS, 8'h00FF, RESP_SLVERR);
    wr(4'hC, 8'h00FF, RESP_SLVERR);
    rd(4'hC, 32'h0000_0000, RESP_SLVERR);
    // a write without byte lane 0 must leave the register alone
    wstrb <= 4'h0;
    wr(ADDR_CONTROL_MAIN, 8'h0000, RESP_OKAY);
    wstrb <= 4'h1;
    rd(ADDR_CONTROL_MAIN, 32'h0000_00A0, RESP_OKAY);
    // second reset in mid-run with the pin routed
    reset_dut();
    repeat (3) @(posedge aclk);
    complete_run();
  end
endmodule : rdac_top_test
`default_nettype wire
